// File: pkg/motor_ctrl_defines.vh
// Register offsets, field layouts, reset values and timing counts.
`ifndef MOTOR_CTRL_DEFINES_VH
`define MOTOR_CTRL_DEFINES_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_SELECT 12'h000
`define OFF_TIMING 12'h004
`define OFF_LEVELS 12'h008
`define OFF_FREQ 12'h00C
`define OFF_CMD 12'h010
`define OFF_STATUS 12'h014
`define OFF_OUTPUT 12'h018
`define OFF_CTRL 12'h01C
// ----------------------------------------------------------------------
// Select register field positions
// ----------------------------------------------------------------------
`define F_ACCESS 3:0
`define F_RUNSRC 5:4
`define F_FRQSRC 7:6
`define F_STOPM 9:8
`define F_KEYPRI 10
`define F_REVINH 11
`define F_UDMEM 12
`define F_SCAN 13
`define F_OLSEL 16:14
`define F_VLIM 17
`define F_STALL 18
`define F_CAP 23:19
`define F_VFC 27:24
`define F_DUTY 28
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SELECT 32'h0000_0000
`define RST_TIMING 32'h0032_0005
`define RST_LEVELS 32'h00A0_0096
`define RST_VLIMIT 16'hFFFF
`define RST_DECEL 16'h0064
// ----------------------------------------------------------------------
// Timing: base tick of 1 ms and the two scan periods
// ----------------------------------------------------------------------
`define CLK_MHZ 125
`define TICK_US 1000
`define TICK_CYCLES (`CLK_MHZ * `TICK_US)
`define SCAN_FAST_MS 5
`define SCAN_SLOW_MS 10
`endif

// File: verilog/ms_tick_gen.v
// Millisecond tick generator used by all blanking timers.
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
  parameter integer CYCLES = 125000
) (
  input wire core_clk,
  input wire rstn,
  output reg tick_q
);
  reg [16:0] cnt_q;
  always @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= 17'h0_0000;
      tick_q <= 1'b0;
    end else if (cnt_q == CYCLES[16:0] - 17'h0_0001) begin
      cnt_q <= 17'h0_0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 17'h0_0001;
      tick_q <= 1'b0;
    end
  end
endmodule // ms_tick_gen
`default_nettype wire

// File: verilog/input_scanner.v
// Two-flop synchroniser and periodic sampler for the input terminals.
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_defines.vh"
module input_scanner #(
  parameter integer WIDTH = 8
) (
  input wire core_clk,
  input wire rstn,
  input wire msTick,
  input wire slowScan,
  input wire [WIDTH-1:0] pins,
  output reg [WIDTH-1:0] sampled_q
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  reg [3:0] ms_q;
  wire [3:0] period;
  assign period = slowScan ? 4'd`SCAN_SLOW_MS : 4'd`SCAN_FAST_MS;
  always @(posedge core_clk) begin
    if (!rstn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
      ms_q <= 4'h0;
      sampled_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      if (msTick) begin
        if (ms_q + 4'h1 >= period) begin
          ms_q <= 4'h0;
          sampled_q <= sync_q;
        end else begin
          ms_q <= ms_q + 4'h1;
        end
      end
    end
  end
endmodule // input_scanner
`default_nettype wire

// File: verilog/motor_run_stop_control.v
// Run and stop control for a motor drive with an APB register file.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_defines.vh"
// Operation
// - Access values 7..12 restore factory defaults except select bits 31:19
// - Odd init values two-wire, even three-wire
// - Run source: keypad, terminals, serial
// - Frequency source: keypad, terminals, serial, pulse
// - Stop mode 0 ramps down at decel
// - Stop mode 1 coasts, blocks run briefly
// - Stop mode 2 waits, then DC brakes
// - Stop mode 3 coasts for computed interval
// - Key priority may ignore keypad STOP
// - Reverse inhibit refuses reverse running
// - Up/down value confirmed, optionally remembered
// - Up/down from keypad and terminals
// - Terminals sampled every 5 or 10 ms
// - Excess load needs sustained overcurrent
// - Detection off, at agree, or always
// - Alarm keeps running, fault stops output
// - Output voltage clamped when limit enabled
// - Stall guard holds frequency rise on overcurrent
// - Access 1 leaves command page and select values 0, 7..12 writable
module motor_run_stop_control #(
  parameter integer TICK_CYCLES = `TICK_CYCLES
) (
  input wire core_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] termPins,
  input wire [15:0] motorCurrent,
  input wire [15:0] pulseFreq,
  input wire [15:0] termFreq,
  input wire [15:0] vfVoltage,
  output reg [15:0] outFreq_q,
  output reg [15:0] outVolt_q,
  output reg outEnable_q,
  output reg outReverse_q,
  output reg dcBrake_q,
  output reg alarmBlink_q,
  output reg faultSteady_q
);
  // --------------------------------------------------------------------
  // State and registers
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RUN = 3'd1;
  localparam [2:0] ST_DECEL = 3'd2;
  localparam [2:0] ST_BLANK = 3'd3;
  localparam [2:0] ST_BRAKE = 3'd4;
  localparam [2:0] ST_FAULT = 3'd5;
  reg [31:0] select_q;
  reg [31:0] timing_q;
  reg [31:0] levels_q;
  reg [15:0] decel1_q;
  reg [15:0] decel2_q;
  reg [15:0] vlimit_q;
  reg decelSel_q;
  reg [15:0] keyFreq_q;
  reg [15:0] pendFreq_q;
  reg [15:0] memFreq_q;
  reg [15:0] serFreq_q;
  reg threeWire_q;
  reg [2:0] state_q;
  reg [15:0] target_q;
  reg [15:0] timer_q;
  reg [15:0] olCnt_q;
  reg [7:0] termPrev_q;
  reg keyRun_q;
  reg keyRev_q;
  reg serRun_q;
  reg serRev_q;
  reg keyStopEv;
  reg keyUpEv;
  reg keyDownEv;
  reg keyConfEv;
  wire msTick;
  wire [7:0] term;
  // Terminal map: 0 fwd/run, 1 rev/stop, 2 dir, 3 up, 4 down.
  ms_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick_q(msTick)
  );
  input_scanner #(
    .WIDTH(8)
  ) u_scan (
    .core_clk(core_clk),
    .rstn(rstn),
    .msTick(msTick),
    .slowScan(select_q[`F_SCAN]),
    .pins(termPins),
    .sampled_q(term)
  );
  // --------------------------------------------------------------------
  // Command selection
  // --------------------------------------------------------------------
  wire [1:0] runSrc = select_q[`F_RUNSRC];
  wire [1:0] stopM = select_q[`F_STOPM];
  wire [2:0] olSel = select_q[`F_OLSEL];
  reg termRun;
  reg termRev;
  reg termLatch_q;
  always @* begin
    if (threeWire_q) begin
      termRun = termLatch_q;
      termRev = term[2];
    end else begin
      termRun = term[0] ^ term[1];
      termRev = term[1];
    end
  end
  reg runCmd;
  reg revCmd;
  always @* begin
    case (runSrc)
      2'd0: begin
        runCmd = keyRun_q;
        revCmd = keyRev_q;
      end
      2'd1: begin
        runCmd = termRun;
        revCmd = termRev;
      end
      2'd2: begin
        runCmd = serRun_q;
        revCmd = serRev_q;
      end
      default: begin
        runCmd = 1'b0;
        revCmd = 1'b0;
      end
    endcase
  end
  reg [15:0] freqCmd;
  always @* begin
    case (select_q[`F_FRQSRC])
      2'd0: freqCmd = keyFreq_q;
      2'd1: freqCmd = termFreq;
      2'd2: freqCmd = serFreq_q;
      default: freqCmd = pulseFreq;
    endcase
  end
  // Keypad STOP may be masked for remote sources.
  wire keyStopOk = !select_q[`F_KEYPRI] || runSrc == 2'd0;
  wire stopReq = !runCmd || (keyStopEv && keyStopOk);
  wire revBad = revCmd && select_q[`F_REVINH];
  wire overI = motorCurrent > levels_q[15:0];
  wire stallI = motorCurrent > levels_q[31:16];
  wire agree = outFreq_q == target_q;
  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Interval scaled by the ratio of the output frequency to full scale.
  function [15:0] scaleTime;
    input [15:0] freq;
    input [15:0] base;
    reg [31:0] prod;
    begin
      prod = freq * base;
      scaleTime = prod[31:16] + 16'h0001;
    end
  endfunction
  function [15:0] stepToward;
    input [15:0] cur;
    input [15:0] goal;
    begin
      if (cur < goal)
        stepToward = cur + 16'h0001;
      else if (cur > goal)
        stepToward = cur - 16'h0001;
      else
        stepToward = cur;
    end
  endfunction
  // --------------------------------------------------------------------
  // Run and stop sequencer
  // --------------------------------------------------------------------
  wire [15:0] activeDecel = decelSel_q ? decel2_q : decel1_q;
  reg [15:0] rateCnt_q;
  wire rateHit = msTick && rateCnt_q == 16'h0000;
  wire olDetect = olCnt_q > timing_q[31:16];
  wire olEnable = olSel != 3'd0 && olSel <= 3'd4;
  wire olWindow = olSel >= 3'd3 || agree;
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      outFreq_q <= 16'h0000;
      outEnable_q <= 1'b0;
      outReverse_q <= 1'b0;
      dcBrake_q <= 1'b0;
      timer_q <= 16'h0000;
      target_q <= 16'h0000;
      rateCnt_q <= 16'h0000;
      olCnt_q <= 16'h0000;
      alarmBlink_q <= 1'b0;
      faultSteady_q <= 1'b0;
      outVolt_q <= 16'h0000;
    end else begin
      if (msTick)
        rateCnt_q <= rateCnt_q == 16'h0000 ? activeDecel : rateCnt_q - 16'h0001;
      if (msTick && timer_q != 16'h0000)
        timer_q <= timer_q - 16'h0001;
      outVolt_q <= (select_q[`F_VLIM] && vfVoltage > vlimit_q) ?
                   vlimit_q : vfVoltage;
      if (state_q == ST_RUN && olEnable && olWindow && overI) begin
        if (msTick && !olDetect)
          olCnt_q <= olCnt_q + 16'h0001;
      end else begin
        olCnt_q <= 16'h0000;
      end
      case (state_q)
        ST_IDLE: begin
          outEnable_q <= 1'b0;
          dcBrake_q <= 1'b0;
          outFreq_q <= 16'h0000;
          if (runCmd && !stopReq && !revBad) begin
            state_q <= ST_RUN;
            outEnable_q <= 1'b1;
            outReverse_q <= revCmd;
            alarmBlink_q <= 1'b0;
          end
        end
        ST_RUN: begin
          target_q <= freqCmd;
          if (rateHit && !(select_q[`F_STALL] && stallI &&
              outFreq_q < freqCmd))
            outFreq_q <= stepToward(outFreq_q, freqCmd);
          if (olDetect && (olSel == 3'd2 || olSel == 3'd4)) begin
            faultSteady_q <= 1'b1;
            outEnable_q <= 1'b0;
            state_q <= ST_FAULT;
          end else begin
            if (olDetect)
              alarmBlink_q <= 1'b1;
            if (stopReq || revBad) begin
              case (stopM)
                2'd0: state_q <= ST_DECEL;
                2'd1: begin
                  outEnable_q <= 1'b0;
                  timer_q <= timing_q[7:0] * 16'h0064;
                  state_q <= ST_BLANK;
                end
                2'd2: begin
                  outEnable_q <= 1'b0;
                  timer_q <= timing_q[7:0] * 16'h0064;
                  target_q <= scaleTime(outFreq_q,
                              {timing_q[15:8], 8'h00});
                  state_q <= ST_BRAKE;
                end
                default: begin
                  outEnable_q <= 1'b0;
                  timer_q <= scaleTime(outFreq_q, activeDecel);
                  state_q <= ST_BLANK;
                end
              endcase
            end
          end
        end
        ST_DECEL: begin
          if (rateHit)
            outFreq_q <= stepToward(outFreq_q, 16'h0000);
          if (outFreq_q == 16'h0000)
            state_q <= ST_IDLE;
        end
        ST_BLANK: begin
          outFreq_q <= 16'h0000;
          if (timer_q == 16'h0000)
            state_q <= ST_IDLE;
        end
        ST_BRAKE: begin
          outFreq_q <= 16'h0000;
          if (timer_q == 16'h0000) begin
            if (!dcBrake_q) begin
              dcBrake_q <= 1'b1;
              timer_q <= target_q;
            end else begin
              dcBrake_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_FAULT: begin
          outEnable_q <= 1'b0;
          outFreq_q <= 16'h0000;
        end
        default: state_q <= ST_IDLE;
      endcase
      if (state_q == ST_FAULT && keyStopEv) begin
        faultSteady_q <= 1'b0;
        state_q <= ST_IDLE;
      end
    end
  end
  // --------------------------------------------------------------------
  // APB slave and parameter store
  // --------------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  // Access level 1 leaves only the command page writable, plus select writes of 0 or 7..12.
  wire locked = select_q[`F_ACCESS] == 4'd1;
  wire wrCfg = wr && !locked;
  wire isInit = pwdata[3:0] >= 4'd7 && pwdata[3:0] <= 4'd12;
  always @(posedge core_clk) begin
    if (!rstn) begin
      select_q <= `RST_SELECT;
      timing_q <= `RST_TIMING;
      levels_q <= `RST_LEVELS;
      decel1_q <= `RST_DECEL;
      decel2_q <= `RST_DECEL;
      vlimit_q <= `RST_VLIMIT;
      decelSel_q <= 1'b0;
      threeWire_q <= 1'b0;
      keyFreq_q <= 16'h0000;
      pendFreq_q <= 16'h0000;
      memFreq_q <= 16'h0000;
      serFreq_q <= 16'h0000;
      keyRun_q <= 1'b0;
      keyRev_q <= 1'b0;
      serRun_q <= 1'b0;
      serRev_q <= 1'b0;
      termPrev_q <= 8'h00;
      termLatch_q <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      keyStopEv <= 1'b0;
      keyUpEv <= 1'b0;
      keyDownEv <= 1'b0;
      keyConfEv <= 1'b0;
    end else begin
      pready <= acc && !pready;
      pslverr <= 1'b0;
      keyStopEv <= 1'b0;
      keyUpEv <= 1'b0;
      keyDownEv <= 1'b0;
      keyConfEv <= 1'b0;
      termPrev_q <= term;
      if (term[1] == 1'b0)
        termLatch_q <= 1'b0;
      else if (term[0])
        termLatch_q <= 1'b1;
      if (acc && !pready) begin
        case (paddr)
          `OFF_SELECT: prdata <= select_q;
          `OFF_TIMING: prdata <= timing_q;
          `OFF_LEVELS: prdata <= levels_q;
          `OFF_FREQ: prdata <= {decel2_q, decel1_q};
          `OFF_CMD: prdata <= {serFreq_q, keyFreq_q};
          `OFF_STATUS: prdata <= {8'h00, term, 5'h00, state_q,
                                  faultSteady_q, alarmBlink_q,
                                  outReverse_q, outEnable_q,
                                  dcBrake_q, threeWire_q,
                                  locked, decelSel_q};
          `OFF_OUTPUT: prdata <= {outVolt_q, outFreq_q};
          `OFF_CTRL: prdata <= {vlimit_q, pendFreq_q};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (wr && !pready) begin
        case (paddr)
          `OFF_SELECT: begin
            if (isInit) begin
              select_q <= {select_q[31:19], 15'h0000, pwdata[3:0]};
              timing_q <= `RST_TIMING;
              levels_q <= `RST_LEVELS;
              decel1_q <= `RST_DECEL;
              decel2_q <= `RST_DECEL;
              vlimit_q <= `RST_VLIMIT;
              threeWire_q <= !pwdata[0];
            end else if (!locked || pwdata[3:0] == 4'd0)
              select_q <= pwdata;
          end
          `OFF_TIMING: if (wrCfg) timing_q <= pwdata;
          `OFF_LEVELS: if (wrCfg) levels_q <= pwdata;
          `OFF_FREQ: if (wrCfg) begin
            decel1_q <= pwdata[15:0];
            decel2_q <= pwdata[31:16];
          end
          `OFF_CMD: begin
            // Bits: 0 run, 1 rev, 2 stop, 3 up, 4 down, 5 enter,
            // 6 serial run, 7 serial rev, 8 decel two, 31:16 serial freq.
            keyRun_q <= pwdata[0] && !pwdata[2];
            keyRev_q <= pwdata[1];
            keyStopEv <= pwdata[2];
            keyUpEv <= pwdata[3];
            keyDownEv <= pwdata[4];
            keyConfEv <= pwdata[5];
            serRun_q <= pwdata[6];
            serRev_q <= pwdata[7];
            decelSel_q <= pwdata[8];
            serFreq_q <= pwdata[31:16];
          end
          `OFF_CTRL: if (wrCfg) vlimit_q <= pwdata[31:16];
          default: ;
        endcase
      end
      // Up/down from keypad or terminal rising edges, staged until confirm.
      if (keyUpEv || (term[3] && !termPrev_q[3]))
        pendFreq_q <= pendFreq_q + 16'h0001;
      else if (keyDownEv || (term[4] && !termPrev_q[4]))
        pendFreq_q <= pendFreq_q - 16'h0001;
      if (keyConfEv) begin
        keyFreq_q <= pendFreq_q;
        if (select_q[`F_UDMEM])
          memFreq_q <= pendFreq_q;
      end else if (state_q == ST_IDLE && runCmd && select_q[`F_UDMEM])
        keyFreq_q <= memFreq_q;
    end
  end
endmodule // motor_run_stop_control
`default_nettype wire

// File: sim/motor_run_stop_monitor.sv
// Concurrent checks on the ports of the run and stop control block.
`timescale 1ns/1ps
`default_nettype none
module motor_run_stop_monitor #(
  parameter integer TICK_CYCLES = 125000
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] termPins,
  input wire logic [15:0] motorCurrent,
  input wire logic [15:0] vfVoltage,
  input wire logic [15:0] outFreq_q,
  input wire logic [15:0] outVolt_q,
  input wire logic outEnable_q,
  input wire logic dcBrake_q,
  input wire logic alarmBlink_q,
  input wire logic faultSteady_q
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence accessStart;
    psel && penable && !$past(penable);
  endsequence
  sequence voltSteady;
    $stable(vfVoltage) [*3];
  endsequence
  a_answer_time: assert property (accessStart |=> pready)
    else $error("bus answer not one cycle after access start");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_error_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error response carries nonzero data");
  a_unmapped_err: assert property ((accessStart ##0 paddr > 12'h01C) |=> pslverr)
    else $error("unmapped address not refused");
  a_reset_clear: assert property ($rose(rstn) |-> !outEnable_q && !dcBrake_q
    && !faultSteady_q && !alarmBlink_q && outFreq_q == 16'h0000)
    else $error("outputs not cleared by reset");
  a_fault_stops: assert property ($rose(faultSteady_q) |-> ##[0:1] !outEnable_q)
    else $error("fault did not shut off output");
  a_fault_holds: assert property (faultSteady_q && $past(faultSteady_q) |-> !outEnable_q)
    else $error("output driven while fault stands");
  a_brake_idle: assert property (dcBrake_q |-> !outEnable_q)
    else $error("braking while output drives");
  a_volt_clamp: assert property (voltSteady |-> outVolt_q <= vfVoltage)
    else $error("output voltage above pattern voltage");
endmodule // motor_run_stop_monitor
bind motor_run_stop_control motor_run_stop_monitor #(.TICK_CYCLES(TICK_CYCLES))
  motor_run_stop_monitor_inst (.core_clk(core_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .termPins(termPins),
  .motorCurrent(motorCurrent), .vfVoltage(vfVoltage), .outFreq_q(outFreq_q),
  .outVolt_q(outVolt_q), .outEnable_q(outEnable_q), .dcBrake_q(dcBrake_q),
  .alarmBlink_q(alarmBlink_q), .faultSteady_q(faultSteady_q));
`default_nettype wire

// File: sim/term_panel.sv
// Terminal panel model that drives the control input contacts.
`timescale 1ns/1ps
`default_nettype none
module term_panel (
  input wire logic fwdRun,
  input wire logic revRun,
  input wire logic upKey,
  input wire logic downKey,
  output logic [7:0] termPins
);
  // ----------------------------------------------------------------
  // Contacts
  // ----------------------------------------------------------------
  // Two-wire wiring only: the direction pin stays open, so three-wire
  // runs are not exercised by this panel.
  assign termPins = {3'b000, downKey, upKey, 1'b0, revRun, fwdRun};
endmodule // term_panel
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the run and stop control block.
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_defines.vh"
module tb_top;
  localparam int TICK = 10;
  localparam logic [31:0] CFG = 32'h0000_0150;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, errVal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [7:0] termPins;
  logic [15:0] motorCurrent, pulseFreq, termFreq, vfVoltage, outFreq, outVolt;
  logic outEnable, outReverse, dcBrake, alarmBlink, faultSteady;
  logic fwdRun, revRun, upKey, downKey;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  motor_run_stop_control #(.TICK_CYCLES(TICK)) motor_run_stop_control_inst (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .termPins(termPins),
    .motorCurrent(motorCurrent), .pulseFreq(pulseFreq), .termFreq(termFreq),
    .vfVoltage(vfVoltage), .outFreq_q(outFreq), .outVolt_q(outVolt),
    .outEnable_q(outEnable), .outReverse_q(outReverse), .dcBrake_q(dcBrake),
    .alarmBlink_q(alarmBlink), .faultSteady_q(faultSteady));
  term_panel term_panel_inst (.fwdRun(fwdRun), .revRun(revRun),
    .upKey(upKey), .downKey(downKey), .termPins(termPins));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until ready is seen at an edge, then idles one
  // cycle so no signal is assigned twice in one time step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdVal, exp);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = outEnable;
      1: pick = alarmBlink;
      2: pick = faultSteady;
      default: pick = dcBrake;
    endcase
  endfunction
  task automatic waitFor(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, pick(w)}, {31'h0, v});
  endtask
  task automatic doReset();
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    motorCurrent = 16'h0000;
    pulseFreq = 16'h0200;
    termFreq = 16'h0100;
    vfVoltage = 16'h8000;
    {fwdRun, revRun, upKey, downKey} = 4'h0;
    doReset();
    rdChk(`OFF_SELECT, 32'h0000_0000);
    rdChk(`OFF_TIMING, `RST_TIMING);
    rdChk(`OFF_LEVELS, `RST_LEVELS);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, errVal}, 32'h0000_0001);
    chk(rdVal, 32'h0000_0000);
    $display("test register reset done");
    wr(`OFF_TIMING, 32'h1234_5678);
    for (int v = 12; v >= 7; v--) begin
      wr(`OFF_SELECT, 32'h1FF8_3FF0);
      wr(`OFF_SELECT, 32'(v));
      rdChk(`OFF_SELECT, 32'h1FF8_0000 | 32'(v));
      rdChk(`OFF_STATUS, v[0] ? 32'h0000_0000 : 32'h0000_0004);
    end
    rdChk(`OFF_TIMING, `RST_TIMING);
    $display("test initialise done");
    wr(`OFF_SELECT, 32'h0000_0001);
    wr(`OFF_TIMING, 32'h0002_0101);
    rdChk(`OFF_TIMING, `RST_TIMING);
    wr(`OFF_SELECT, 32'h0000_0000);
    wr(`OFF_TIMING, 32'h0002_0101);
    rdChk(`OFF_TIMING, 32'h0002_0101);
    $display("test access lock done");
    wr(`OFF_SELECT, CFG);
    fwdRun <= 1'b1;
    waitFor(0, 1'b1, 300);
    fwdRun <= 1'b0;
    waitFor(0, 1'b0, 300);
    fwdRun <= 1'b1;
    repeat (400) @(posedge core_clk);
    chk({31'h0, outEnable}, 32'h0000_0000);
    waitFor(0, 1'b1, 1300);
    $display("test coast stop done");
    fwdRun <= 1'b0;
    waitFor(0, 1'b0, 300);
    repeat (1200) @(posedge core_clk);
    wr(`OFF_SELECT, CFG | 32'h0000_0800);
    revRun <= 1'b1;
    repeat (300) @(posedge core_clk);
    chk({30'h0, outEnable, outReverse}, 32'h0000_0000);
    wr(`OFF_SELECT, CFG);
    waitFor(0, 1'b1, 300);
    chk({31'h0, outReverse}, 32'h0000_0001);
    revRun <= 1'b0;
    waitFor(0, 1'b0, 300);
    repeat (1200) @(posedge core_clk);
    fwdRun <= 1'b1;
    waitFor(0, 1'b1, 300);
    $display("test reverse done");
    wr(`OFF_SELECT, CFG | 32'h0000_C000);
    motorCurrent <= 16'h0200;
    repeat (10) @(posedge core_clk);
    motorCurrent <= 16'h0000;
    repeat (60) @(posedge core_clk);
    chk({31'h0, alarmBlink}, 32'h0000_0000);
    motorCurrent <= 16'h0200;
    waitFor(1, 1'b1, 300);
    chk({31'h0, outEnable}, 32'h0000_0001);
    motorCurrent <= 16'h0000;
    wr(`OFF_SELECT, CFG | 32'h0001_0000);
    motorCurrent <= 16'h0200;
    waitFor(2, 1'b1, 300);
    chk({31'h0, outEnable}, 32'h0000_0000);
    $display("test excess load done");
    fwdRun <= 1'b0;
    doReset();
    wr(`OFF_SELECT, 32'h0000_0007);
    wr(`OFF_FREQ, 32'h0000_0000);
    wr(`OFF_CTRL, 32'h0100_0000);
    wr(`OFF_SELECT, CFG | 32'h0006_0000);
    termFreq <= 16'h0008;
    fwdRun <= 1'b1;
    waitFor(0, 1'b1, 300);
    repeat (40) @(posedge core_clk);
    chk({16'h0, outVolt}, 32'h0000_0100);
    chk({16'h0, outFreq}, 32'h0000_0000);
    chk({30'h0, alarmBlink, faultSteady}, 32'h0000_0000);
    motorCurrent <= 16'h0000;
    repeat (120) @(posedge core_clk);
    chk({16'h0, outFreq}, 32'h0000_0008);
    $display("test voltage limit done");
    wr(`OFF_SELECT, 32'h0002_0050);
    fwdRun <= 1'b0;
    waitFor(0, 1'b0, 300);
    chk({16'h0, outFreq}, 32'h0000_0000);
    wr(`OFF_SELECT, 32'h0002_0250);
    fwdRun <= 1'b1;
    waitFor(0, 1'b1, 300);
    repeat (120) @(posedge core_clk);
    fwdRun <= 1'b0;
    waitFor(0, 1'b0, 300);
    repeat (4500) @(posedge core_clk);
    chk({31'h0, dcBrake}, 32'h0000_0000);
    waitFor(3, 1'b1, 1000);
    waitFor(3, 1'b0, 100);
    $display("test stop methods done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
